/* hw/cfd_bit_clock.sv */
// Quantum prescaler and bit segment sequencer with resynchronisation
module cfd_bit_clock (
    input  wire logic                core_clk,
    input  wire logic                rst_n,
    input  wire logic                run,
    input  wire cfd_pkg::cfd_timing_t timing,
    input  wire logic                rxLevel,
    output logic                     samplePulse,
    output logic                     tooFast
);
    import cfd_pkg::*;

    logic [5:0] qCnt;
    logic       qTick;
    cfd_seg_t   state;
    logic [4:0] tq;
    logic [2:0] ext;
    logic [2:0] cut;
    logic [2:0] sjwLen;
    logic       rxPrev;
    logic       resyncDone;
    logic       fall;
    logic [11:0] bitClks;

    assign sjwLen = {1'b0, timing.jumpWidth} + 3'h1;
    assign fall = rxPrev & ~rxLevel;

    ////////////////////////////////////////////////////////////////////////
    // quantum from prescaler
    always_ff @(posedge core_clk) begin
        if (!rst_n || !run || qTick) begin
            qCnt <= 6'h00;
        end else begin
            qCnt <= qCnt + 6'h01;
        end
    end
    assign qTick = run && (qCnt == timing.quantumPrescaler);

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            rxPrev <= 1'b1;
        end else begin
            rxPrev <= rxLevel;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // segment lengths, jump limit
    always_ff @(posedge core_clk) begin
        if (!rst_n || !run) begin
            state <= ST_SYNC;
            tq <= 5'h00;
            ext <= 3'h0;
            cut <= 3'h0;
            resyncDone <= 1'b0;
        end else begin
            if (fall && !resyncDone && state == ST_SEG1) begin
                ext <= (tq[2:0] + 3'h1 < sjwLen && tq < 5'h7) ?
                       tq[2:0] + 3'h1 : sjwLen;
                resyncDone <= 1'b1;
            end else if (fall && !resyncDone && state == ST_SEG2) begin
                cut <= sjwLen;
                resyncDone <= 1'b1;
            end
            if (qTick) begin
                case (state)
                    ST_SYNC: begin
                        state <= ST_SEG1;
                        tq <= 5'h00;
                        ext <= 3'h0;
                        cut <= 3'h0;
                        resyncDone <= 1'b0;
                    end
                    ST_SEG1: begin
                        if (tq >= {1'b0, timing.segmentOneLen} + {2'b00, ext})
                        begin
                            state <= ST_SEG2;
                            tq <= 5'h00;
                        end else begin
                            tq <= tq + 5'h01;
                        end
                    end
                    ST_SEG2: begin
                        if (tq + {2'b00, cut} >= {2'b00, timing.segmentTwoLen})
                        begin
                            state <= ST_SYNC;
                        end else begin
                            tq <= tq + 5'h01;
                        end
                    end
                    default: state <= ST_SYNC;
                endcase
            end
        end
    end

    assign samplePulse = qTick && state == ST_SEG1 &&
        tq >= {1'b0, timing.segmentOneLen} + {2'b00, ext};

    assign bitClks = 12'({6'h00, timing.quantumPrescaler} + 12'h001) *
        12'(5'h03 + {1'b0, timing.segmentOneLen}
            + {2'b00, timing.segmentTwoLen});
    assign tooFast = bitClks < MIN_BIT_CLKS;

    ////////////////////////////////////////////////////////////////////////
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    jump_limit_a: assert property (ext <= sjwLen && cut <= sjwLen)
        else $error("resync exceeds jump width");
    seg2_end_a: assert property (
        qTick && state == ST_SEG2 && cut == 3'h0 &&
        tq == {2'b00, timing.segmentTwoLen} |=> state == ST_SYNC)
        else $error("segment two overran");
endmodule

/* hw/cfd_fault_diag.sv */
// CAN fault counters, bus diagnosis and bit timing with an APB slave
//
// Decided for this implementation: the address map and register access over APB.
module cfd_fault_diag (
    input  wire logic              core_clk,
    input  wire logic              rst_n,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [7:0]        paddr,
    input  wire logic [31:0]       pwdata,
    output logic [31:0]            prdata,
    output logic                   pready,
    output logic                   pslverr,
    input  wire logic              canRxPin,
    output logic                   canTxPin,
    input  wire logic              txBit,
    input  wire cfd_pkg::cfd_evt_t evt,
    output logic                   sampleBit,
    output logic                   samplePulse,
    output logic                   errPassive,
    output logic                   busOff,
    output logic                   storeMsg,
    output logic                   irq
);
    import cfd_pkg::*;

    logic [8:0]  tx_error_counter;
    logic [7:0]  rx_error_counter;
    logic        silentSelect;
    logic        loopbackSelect;
    logic [7:0]  prescale;
    logic [7:0]  segments;
    logic        cfgMode;
    logic [IRQ_W-1:0] irqStat;
    logic [IRQ_W-1:0] irqMask;
    logic [IRQ_W-1:0] irqEvt;
    logic        rxS1;
    logic        rxS2;
    logic        rxS3;
    logic        rxLive;
    logic        rxInt;
    logic        lastSample;
    logic        tooFast;
    logic        setupRd;
    logic        wrEn;
    logic        access;
    logic        mapped;
    logic        locked;
    logic [7:0]  rdByte;
    logic        passNow;
    logic        ackArm;
    logic [2:0]  ackCnt;
    cfd_timing_t timing;

    ////////////////////////////////////////////////////////////////////////
    // Bus decode: zero wait states, read data latched in the setup cycle
    assign access  = psel && penable;
    assign setupRd = psel && !penable && !pwrite;
    assign pready  = 1'b1;
    assign mapped  = paddr[1:0] == 2'b00 && paddr <= ADDR_IRQ_MASK;

    assign locked  = !cfgMode &&
        (paddr == ADDR_PRESCALE || paddr == ADDR_SEGMENTS);
    assign pslverr = access && (!mapped || locked);
    assign wrEn    = access && pwrite && mapped && !locked;

    always_comb begin
        rdByte = 8'h00;
        case (paddr)
            ADDR_TX_FAULT: rdByte = tx_error_counter[7:0];
            ADDR_RX_FAULT: rdByte = rx_error_counter;
            ADDR_DIAG: rdByte = {4'h0, rxLive, lastSample,
                                 silentSelect, loopbackSelect};
            ADDR_PRESCALE: rdByte = locked ? 8'h00 : prescale;
            ADDR_SEGMENTS: rdByte = locked ? 8'h00 : {1'b0, segments[6:0]};
            ADDR_CTRL: rdByte = {7'h00, cfgMode};
            ADDR_IRQ_STAT: rdByte = {{(8-IRQ_W){1'b0}}, irqStat};
            ADDR_IRQ_MASK: rdByte = {{(8-IRQ_W){1'b0}}, irqMask};
            default: rdByte = 8'h00;
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            prdata <= 32'h0000_0000;
        end else if (setupRd) begin
            prdata <= {24'h00_0000, rdByte};
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Software control registers
    // silent and loop-back selects
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            silentSelect <= 1'b0;
            loopbackSelect <= 1'b0;
        end else if (wrEn && paddr == ADDR_DIAG) begin
            silentSelect <= pwdata[DIAG_SIL];
            loopbackSelect <= pwdata[DIAG_LBK];
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            prescale <= PRESCALE_RST;
            segments <= SEGMENTS_RST;
        end else if (wrEn && paddr == ADDR_PRESCALE) begin
            prescale <= pwdata[7:0];
        end else if (wrEn && paddr == ADDR_SEGMENTS) begin
            segments <= {1'b0, pwdata[6:0]};
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            cfgMode <= CTRL_CFG_RST;
        end else if (wrEn && paddr == ADDR_CTRL) begin
            cfgMode <= pwdata[CTRL_CFG];
        end
    end

    assign timing = '{jumpWidth: prescale[7:6],
                      quantumPrescaler: prescale[5:0],
                      segmentTwoLen: segments[6:4],
                      segmentOneLen: segments[3:0]};

    ////////////////////////////////////////////////////////////////////////
    // Receive pin: three stages, a level change counts once two agree
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            rxS1 <= 1'b1;
            rxS2 <= 1'b1;
            rxS3 <= 1'b1;
        end else begin
            rxS1 <= canRxPin;
            rxS2 <= rxS1;
            rxS3 <= rxS2;
        end
    end

    // live level, which software polls at diagnosis bit 3
    // dominant level visible four clocks after the pin
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            rxLive <= 1'b1;
        end else if (rxS2 == rxS3) begin
            rxLive <= rxS3;
        end
    end

    // loop-back feeds transmit into receive; silent holds pin recessive
    assign rxInt = loopbackSelect ? txBit : rxLive;
    assign canTxPin = silentSelect ? 1'b1 : txBit;

    cfd_bit_clock u_bit_clock (
        .core_clk    (core_clk),
        .rst_n       (rst_n),
        .run         (!cfgMode),
        .timing      (timing),
        .rxLevel     (rxInt),
        .samplePulse (samplePulse),
        .tooFast     (tooFast)
    );

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            lastSample <= 1'b1;
        end else if (samplePulse) begin
            lastSample <= rxInt;
        end
    end
    assign sampleBit = lastSample;

    ////////////////////////////////////////////////////////////////////////
    // Fault confinement counters, saturating rather than wrapping
    // receive counter update
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            rx_error_counter <= 8'h00;
        end else if (evt.rxErr8) begin
            rx_error_counter <= (rx_error_counter > REC_TOP8) ? 8'hFF : rx_error_counter + REC_STEP;
        end else if (evt.rxErr1) begin
            rx_error_counter <= (rx_error_counter == 8'hFF) ? 8'hFF : rx_error_counter + 8'h01;
        end else if (evt.rxOk) begin
            if (rx_error_counter > REC_HIGH) begin
                rx_error_counter <= REC_RELOAD;
            end else if (rx_error_counter != 8'h00) begin
                rx_error_counter <= rx_error_counter - 8'h01;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            tx_error_counter <= 9'h000;
        end else if (evt.txErr8) begin
            tx_error_counter <= (tx_error_counter > TEC_TOP8) ? 9'h1FF : tx_error_counter + TEC_STEP;
        end else if (evt.txOk && tx_error_counter != 9'h000) begin
            tx_error_counter <= tx_error_counter - 9'h001;
        end
    end

    assign passNow = rx_error_counter > REC_PASSIVE || tx_error_counter > TEC_PASSIVE;
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            errPassive <= 1'b0;
            busOff <= 1'b0;
        end else begin
            errPassive <= passNow;
            busOff <= tx_error_counter[8];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // store six bits after acknowledge
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            ackArm <= 1'b0;
            ackCnt <= 3'h0;
            storeMsg <= 1'b0;
        end else begin
            storeMsg <= 1'b0;
            if (evt.ackSeen) begin
                ackArm <= 1'b1;
                ackCnt <= 3'h0;
            end else if (ackArm && samplePulse) begin
                ackCnt <= ackCnt + 3'h1;
                if (ackCnt + 3'h1 == STORE_BITS) begin
                    ackArm <= 1'b0;
                    storeMsg <= 1'b1;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Interrupts: a new event wins over a same-cycle write-one-to-clear
    assign irqEvt[IRQ_PASSIVE] = passNow && !errPassive;
    assign irqEvt[IRQ_BUSOFF]  = tx_error_counter[8] && !busOff;
    assign irqEvt[IRQ_STORE]   = storeMsg;
    assign irqEvt[IRQ_RATE]    = tooFast && !cfgMode;

    for (genvar i = 0; i < IRQ_W; i++) begin : g_irq
        always_ff @(posedge core_clk) begin
            if (!rst_n) begin
                irqStat[i] <= 1'b0;
            end else if (irqEvt[i]) begin
                irqStat[i] <= 1'b1;
            end else if (wrEn && paddr == ADDR_IRQ_STAT && pwdata[i]) begin
                irqStat[i] <= 1'b0;
            end
        end
        always_ff @(posedge core_clk) begin
            if (!rst_n) begin
                irqMask[i] <= 1'b0;
            end else if (wrEn && paddr == ADDR_IRQ_MASK) begin
                irqMask[i] <= pwdata[i];
            end
        end
    end
    assign irq = |(irqStat & irqMask);

    ////////////////////////////////////////////////////////////////////////
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    rec_step_eight_a: assert property (
        evt.rxErr8 && rx_error_counter <= REC_TOP8 |=> rx_error_counter == $past(rx_error_counter) + REC_STEP)
        else $error("receive counter did not rise by eight");
    rec_step_one_a: assert property (
        evt.rxErr1 && !evt.rxErr8 && rx_error_counter != 8'hFF
        |=> rx_error_counter == $past(rx_error_counter) + 8'h01)
        else $error("receive counter did not rise by one");
    rec_reload_a: assert property (
        evt.rxOk && !evt.rxErr1 && !evt.rxErr8 && rx_error_counter > REC_HIGH
        |=> rx_error_counter == REC_RELOAD)
        else $error("receive counter not reloaded");
    passive_entry_a: assert property (
        rx_error_counter > REC_PASSIVE |=> errPassive)
        else $error("error passive not entered");
    tx_byte_read_a: assert property (
        setupRd && paddr == ADDR_TX_FAULT ##1 access
        |-> prdata[7:0] == $past(tx_error_counter[7:0]) && prdata[31:8] == 24'h0)
        else $error("transmit counter read wrong");
    live_rx_read_a: assert property (
        setupRd && paddr == ADDR_DIAG |=> prdata[DIAG_RX] == $past(rxLive))
        else $error("live receive level read wrong");
    live_rx_follow_a: assert property (
        rxS3 == rxS2 ##1 rxS3 == $past(rxS3) |-> rxLive == $past(rxS3))
        else $error("live receive level stale");
    sample_take_a: assert property (
        samplePulse |=> lastSample == $past(rxInt))
        else $error("sample point value wrong");
    sample_hold_a: assert property (
        !samplePulse |=> $stable(lastSample))
        else $error("sample value changed between sample points");
    silent_tx_a: assert property (silentSelect |-> canTxPin)
        else $error("silent mode drove the bus");
    cfg_lock_a: assert property (
        access && pwrite && paddr == ADDR_PRESCALE && !cfgMode
        |-> pslverr ##1 $stable(prescale))
        else $error("timing written outside configuration");
    seg_top_zero_a: assert property (segments[7] == 1'b0)
        else $error("reserved timing bit set");
    store_delay_a: assert property (
        evt.ackSeen |=> !storeMsg [*8])
        else $error("message stored too early");

    rl_store_c: cover property (ackArm ##[1:1000] storeMsg);
    rl_passive_c: cover property (!errPassive ##1 errPassive);
    rl_loop_c: cover property (loopbackSelect && samplePulse);
    rl_irq_c: cover property (!irq ##1 irq);
endmodule

/* hw/cfd_pkg.sv */
// Constants and carrier types for the CAN fault confinement and timing block
// Operation
// - Software reads the low byte of the nine-bit transmit error counter.
// - A receive error raises the receive error counter by one or eight.
// - A good reception lowers it by one, or reloads 120 if above 128.
// - The block is error passive while the receive counter exceeds 127.
// - Diagnosis bit 3 reads the live level of the receive pin.
// - Diagnosis bit 2 reads the bus value taken at the last sample point.
// - Diagnosis bit 1 selects silent mode and bit 0 selects loop-back.
// - The first bit-timing register is reachable only in configuration mode.
// - Resync may stretch or shrink a bit by jump width plus one quanta.
// - The time quantum lasts prescaler plus one clock periods.
// - Bit 7 of the second bit-timing register always reads zero.
// - Time segment 2 lasts its field plus one quanta.
// - A bit shorter than eight clocks exceeds the top rate and is flagged.
// - A message is stored no sooner than six bits after acknowledge.
package cfd_pkg;
    localparam logic [7:0] ADDR_TX_FAULT  = 8'h00;
    localparam logic [7:0] ADDR_RX_FAULT  = 8'h04;
    localparam logic [7:0] ADDR_DIAG      = 8'h08;
    localparam logic [7:0] ADDR_PRESCALE  = 8'h0C;
    localparam logic [7:0] ADDR_SEGMENTS  = 8'h10;
    localparam logic [7:0] ADDR_CTRL      = 8'h14;
    localparam logic [7:0] ADDR_IRQ_STAT  = 8'h18;
    localparam logic [7:0] ADDR_IRQ_MASK  = 8'h1C;

    localparam int DIAG_RX   = 3;
    localparam int DIAG_LAST_SAMPLE_VALUE = 2;
    localparam int DIAG_SIL  = 1;
    localparam int DIAG_LBK  = 0;
    localparam int CTRL_CFG  = 0;

    localparam logic [7:0] PRESCALE_RST = 8'h00;
    localparam logic [7:0] SEGMENTS_RST = 8'h23;
    localparam logic       CTRL_CFG_RST = 1'b1;

    localparam logic [7:0] REC_PASSIVE = 8'h7F;
    localparam logic [7:0] REC_HIGH    = 8'h80;
    localparam logic [7:0] REC_RELOAD  = 8'h78;
    localparam logic [7:0] REC_STEP    = 8'h08;
    localparam logic [7:0] REC_TOP8    = 8'hF7;
    localparam logic [8:0] TEC_PASSIVE = 9'h07F;
    localparam logic [8:0] TEC_STEP    = 9'h008;
    localparam logic [8:0] TEC_TOP8    = 9'h1F7;
    localparam logic [2:0] STORE_BITS  = 3'h6;
    localparam logic [11:0] MIN_BIT_CLKS = 12'h008;

    localparam int IRQ_PASSIVE = 0;
    localparam int IRQ_BUSOFF  = 1;
    localparam int IRQ_STORE   = 2;
    localparam int IRQ_RATE    = 3;
    localparam int IRQ_W       = 4;

    typedef struct packed {
        logic rxErr1;
        logic rxErr8;
        logic rxOk;
        logic txErr8;
        logic txOk;
        logic ackSeen;
    } cfd_evt_t;

    typedef struct packed {
        logic [1:0] jumpWidth;
        logic [5:0] quantumPrescaler;
        logic [2:0] segmentTwoLen;
        logic [3:0] segmentOneLen;
    } cfd_timing_t;

    typedef enum logic [2:0] {
        ST_SYNC = 3'b001,
        ST_SEG1 = 3'b010,
        ST_SEG2 = 3'b100
    } cfd_seg_t;
endpackage

/* tb/cfd_bus_node.sv */
// Far bus node model: wired-AND bus seen by the block
module cfd_bus_node (
    input  wire logic canTxPin,
    input  wire logic dominant,
    output logic      canRxPin
);
    timeunit 1ns;
    timeprecision 1ps;
    // shared bus level
    // A dominant node pulls the line low; idle stays recessive high
    assign canRxPin = canTxPin & ~dominant;
endmodule

/* tb/cfd_fault_diag_bench.sv */
// Self-checking bench for the fault counters, diagnosis and bit timing
module cfd_fault_diag_bench import cfd_pkg::*; ;
    timeunit 1ns;
    timeprecision 1ps;
    logic        core_clk, rst_n, psel, penable, pwrite, txBit, dominant;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd;
    logic        pready, pslverr, canRxPin, canTxPin, sampleBit;
    logic        samplePulse, errPassive, busOff, storeMsg, irq, er;
    cfd_evt_t    evt;
    int          nErrors, samplesChecked, n, k;
    logic [7:0]  rstAddr [5] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10};
    logic [7:0]  rstVal [5]  = '{8'h00, 8'h00, 8'h0C, 8'h00, 8'h23};

    cfd_fault_diag uut (.core_clk(core_clk), .rst_n(rst_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .canRxPin(canRxPin), .canTxPin(canTxPin), .txBit(txBit), .evt(evt),
        .sampleBit(sampleBit), .samplePulse(samplePulse),
        .errPassive(errPassive), .busOff(busOff), .storeMsg(storeMsg),
        .irq(irq));
    cfd_bus_node node (.canTxPin(canTxPin), .dominant(dominant),
        .canRxPin(canRxPin));

    initial begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end

    task automatic endOfTest;
        $display("Checks %0d errors %0d", samplesChecked, nErrors);
        if (nErrors == 0 && samplesChecked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic chk(input string name, input logic [31:0] expv,
                       input logic [31:0] got);
        samplesChecked++;
        if (got !== expv) begin
            nErrors++;
            $display("Error %s expected %h seen %h", name, expv, got);
        end
    endtask

    // Setup edge, access phase held until pready is sampled high
    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] d);
        int i;
        @(posedge core_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        i = 0;
        do begin
            @(posedge core_clk);
            i++;
        end while (pready !== 1'b1 && i < 50);
        if (i >= 50) begin
            nErrors++;
            endOfTest;
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rdc(input string name, input logic [7:0] a,
                       input logic [31:0] expv, input logic expErr);
        apb(1'b0, a, 32'h0);
        chk(name, expv, rd);
        chk("pslverr", {31'h0, expErr}, {31'h0, er});
    endtask

    task automatic pulse(input cfd_evt_t e, input int cnt);
        repeat (cnt) begin
            @(posedge core_clk);
            evt <= e;
            @(posedge core_clk);
            evt <= '0;
        end
        repeat (3) @(posedge core_clk);
    endtask

    task automatic waitPulse;
        n = 0;
        do begin
            @(posedge core_clk);
            n++;
        end while (samplePulse !== 1'b1 && n < 400);
        if (n >= 400) begin
            nErrors++;
            endOfTest;
        end
    endtask

    task automatic runCfg(input logic [7:0] pre, input logic [7:0] seg,
                          input int per, input logic fast);
        apb(1'b1, ADDR_CTRL, 32'h01);
        apb(1'b1, ADDR_PRESCALE, {24'h0, pre});
        apb(1'b1, ADDR_SEGMENTS, {24'h0, seg});
        apb(1'b1, ADDR_IRQ_STAT, 32'h0F);
        apb(1'b1, ADDR_CTRL, 32'h00);
        repeat (3) waitPulse;
        chk("bit period", per, n);
        apb(1'b0, ADDR_IRQ_STAT, 32'h0);
        chk("rate flag", {31'h0, fast}, {31'h0, rd[IRQ_RATE]});
    endtask

    initial begin
        rst_n = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        txBit = 1'b1;
        dominant = 1'b0;
        evt = '0;
        nErrors = 0;
        samplesChecked = 0;
        repeat (8) @(posedge core_clk);
        rst_n <= 1'b1;
        for (k = 0; k < 5; k++) begin
            rdc("reset value", rstAddr[k], {24'h0, rstVal[k]}, 1'b0);
        end
        apb(1'b1, ADDR_TX_FAULT, 32'hFF);
        rdc("tx count ro", ADDR_TX_FAULT, 32'h00, 1'b0);
        rdc("unmapped", 8'h20, 32'h0, 1'b1);
        rdc("unaligned", 8'h02, 32'h0, 1'b1);
        apb(1'b1, ADDR_SEGMENTS, 32'hFF);
        rdc("segments", ADDR_SEGMENTS, 32'h7F, 1'b0);
        apb(1'b1, ADDR_PRESCALE, 32'hC5);
        rdc("prescale", ADDR_PRESCALE, 32'hC5, 1'b0);
        apb(1'b1, ADDR_IRQ_MASK, 32'h01);
        pulse(6'b010000, 17);
        chk("passive", 32'h1, {31'h0, errPassive});
        chk("irq set", 32'h1, {31'h0, irq});
        rdc("rec up 8", ADDR_RX_FAULT, 32'h88, 1'b0);
        pulse(6'b001000, 1);
        rdc("rec reload", ADDR_RX_FAULT, 32'h78, 1'b0);
        pulse(6'b100000, 8);
        chk("passive 128", 32'h1, {31'h0, errPassive});
        pulse(6'b001000, 1);
        rdc("rec down 1", ADDR_RX_FAULT, 32'h7F, 1'b0);
        chk("active 127", 32'h0, {31'h0, errPassive});
        apb(1'b1, ADDR_IRQ_STAT, 32'h01);
        @(posedge core_clk);
        chk("irq clear", 32'h0, {31'h0, irq});
        pulse(6'b000100, 2);
        rdc("tec", ADDR_TX_FAULT, 32'h10, 1'b0);
        apb(1'b1, ADDR_DIAG, 32'h02);
        txBit <= 1'b0;
        apb(1'b0, ADDR_DIAG, 32'h0);
        chk("silent tx", 32'h1, {31'h0, canTxPin});
        chk("mode bits", 32'h2, rd & 32'h3);
        apb(1'b1, ADDR_DIAG, 32'h01);
        apb(1'b0, ADDR_DIAG, 32'h0);
        chk("normal tx", 32'h0, {31'h0, canTxPin});
        chk("loop bits", 32'h1, rd & 32'h3);
        apb(1'b1, ADDR_DIAG, 32'h00);
        txBit <= 1'b1;
        runCfg(8'h00, 8'h14, 8, 1'b0);
        runCfg(8'h00, 8'h12, 6, 1'b1);
        runCfg(8'h01, 8'h14, 16, 1'b0);
        rdc("cfg locked", ADDR_PRESCALE, 32'h0, 1'b1);
        apb(1'b1, ADDR_PRESCALE, 32'h3F);
        chk("lock write", 32'h1, {31'h0, er});
        dominant <= 1'b1;
        k = 0;
        // Poll the live level until dominance is seen
        do begin
            apb(1'b0, ADDR_DIAG, 32'h0);
            k++;
        end while (rd[DIAG_RX] !== 1'b0 && k < 20);
        chk("live rx", 32'h0, {31'h0, rd[DIAG_RX]});
        repeat (2) waitPulse;
        apb(1'b0, ADDR_DIAG, 32'h0);
        chk("sample bit", 32'h0, {31'h0, rd[DIAG_LAST_SAMPLE_VALUE]});
        chk("sample port", 32'h0, {31'h0, sampleBit});
        dominant <= 1'b0;
        waitPulse;
        pulse(6'b000001, 1);
        k = 0;
        n = 0;
        while (storeMsg !== 1'b1 && n < 400) begin
            if (samplePulse === 1'b1) begin
                k++;
            end
            @(posedge core_clk);
            n++;
        end
        chk("store delay", 32'd6, k);
        // Silent plus loop-back: pin stays recessive, samples follow txBit
        apb(1'b1, ADDR_DIAG, 32'h03);
        txBit <= 1'b0;
        repeat (2) waitPulse;
        apb(1'b0, ADDR_DIAG, 32'h0);
        chk("loop diag", 32'h0B, rd);
        txBit <= 1'b1;
        apb(1'b1, ADDR_DIAG, 32'h00);
        pulse(6'b000100, 31);
        chk("bus off", 32'h1, {31'h0, busOff});
        rdc("tec low byte", ADDR_TX_FAULT, 32'h08, 1'b0);
        apb(1'b1, ADDR_CTRL, 32'h01);
        rdc("prescale kept", ADDR_PRESCALE, 32'h01, 1'b0);
        endOfTest;
    end
endmodule
